// >>> logic/rcsoc_pkg.sv
// Constants and carrier types for the reference select and output control block
package rcsoc_pkg;

    localparam int CLK_PERIOD_NS = 5;

    localparam logic [7:0] REG_PIN = 8'h10;
    localparam logic [7:0] REG_XIN = 8'h11;
    localparam logic [7:0] REG_XOUT = 8'h12;
    localparam logic [7:0] REG_SRC = 8'h13;
    localparam logic [7:0] REG_OUT_EN = 8'h14;
    localparam logic [7:0] REG_OUT_SW = 8'h15;
    localparam logic [7:0] REG_ADDR_SEL = 8'h16;
    localparam logic [7:0] REG_STATUS = 8'h17;
    localparam logic [7:0] REG_OTP = 8'h72;

    localparam int PIN_FUNC_BIT = 0;
    localparam int PIN_POL_BIT = 1;
    localparam int SRC_PRIM_BIT = 1;
    localparam int SRC_SM_LSB = 6;
    localparam int OTP_RESTORE_BIT = 0;
    localparam int OTP_SAVE_BIT = 3;
    localparam int ADDR_ALT_BIT = 0;

    localparam logic [7:0] I2C_ADDR_DEF = 8'hD4;
    localparam logic [7:0] I2C_ADDR_ALT = 8'hD0;
    localparam logic [7:0] CMD_SAVE = 8'h08;
    localparam logic [7:0] CMD_RESTORE = 8'h01;

    localparam int OTP_OP_NS = 2000;
    localparam int OTP_OP_CYC = (OTP_OP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SW_GAP_NS = 100;
    localparam int SW_GAP_CYC = (SW_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int OUT_NUM = 3;
    localparam logic [1:0] OM_ACTIVE = 2'h0;
    localparam logic [1:0] OM_HILO = 2'h1;
    localparam logic [1:0] OM_TRI = 2'h2;
    localparam logic [5:0] ALL_HILO = 6'h15;

    typedef struct packed {
        logic [1:0] sm;
        logic prim;
        logic pol;
        logic func;
        logic [5:0] xin;
        logic [5:0] xout;
        logic [2:0] oe;
        logic [2:0] os;
        logic addr_alt;
    } rcsoc_cfg_t;

    typedef struct packed {
        logic power_down;
        logic ref_sel;
        logic [5:0] xin_trim;
        logic [5:0] xout_trim;
        logic [5:0] out_mode;
    } rcsoc_ctrl_t;

    // All switch bits on, default bus address
    localparam rcsoc_cfg_t CFG_RESET = 24'h00000E;
    localparam rcsoc_cfg_t OTP_FACTORY = 24'h00000E;

endpackage

// >>> logic/rcsoc_core.sv
// Reference select, crystal trim, OTP command and output gating control
// Summary of operation
// - Select pin picks crystal or differential reference
// - Primary bit names which input is primary
// - Manual switchover when mode upper bit zero
// - Manual mode: select pin picks primary/secondary
// - Active source is primary XOR select pin
// - Source switch causes no output glitch
// - Six-bit trim, 9pF plus 0.5pF steps
// - Two crystal pin trims set independently
// - Save trigger copies registers into OTP
// - Restore trigger reloads registers from OTP
// - Run after STOP, no acks while busy
// - Auto restore at power-up before programming
// - Bus address 0xD4, alternate 0xD0
// - Pin polarity follows polarity bit in enable mode; shutdown takes pin high
// - Function bit: shutdown or output enable
// - Shutdown powers down, outputs driven disabled
// - Function high and pin high: global shutdown
// - Switch bit zero tri-states the output
// - Enable bit one disables on asserted pin
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module rcsoc_core import rcsoc_pkg::*; (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic input_select_pin,
    input wire logic shutdown_or_enable_pin,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output rcsoc_ctrl_t clk_ctrl,
    output logic otp_busy
);

    typedef enum logic [4:0] {
        I_IDLE = 5'b00001,
        I_ADDR = 5'b00010,
        I_ACK = 5'b00100,
        I_DATA = 5'b01000,
        I_SKIP = 5'b10000
    } rcsoc_i2c_t;

    typedef enum logic [2:0] {
        W_RUN = 3'b001,
        W_GATE = 3'b010,
        W_SETTLE = 3'b100
    } rcsoc_sw_t;

    rcsoc_cfg_t cfg;
    rcsoc_cfg_t otp_store;
    rcsoc_ctrl_t next_ctrl;
    rcsoc_i2c_t ist;
    rcsoc_sw_t sw;
    logic [1:0] sel_s, sd_s, scl_s, sda_s;
    logic scl_d, sda_d;
    logic [8:0] otp_cnt;
    logic otp_save, por_pend, otp_done;
    logic req_save, req_restore;
    logic [3:0] bitcnt;
    logic [7:0] shreg, cmd;
    logic cmd_ok, go;
    logic scl_rise, scl_fall, start, stop;
    logic [6:0] my_addr;
    logic active_src, want_src, manual, gated;
    logic [4:0] gcnt;
    logic shutdown, pin_asserted;
    logic [7:0] next_rdata;

    function automatic logic [1:0] out_mode_f(input rcsoc_cfg_t c, input logic asrt,
                                               input int i);
        logic [1:0] m;
        m = OM_ACTIVE;
        if (!c.os[i]) begin
            m = OM_TRI;
        end else if (c.oe[i] && (c.func ? c.pol : asrt)) begin
            m = OM_HILO;
        end
        return m;
    endfunction

    // Pins and both bus lines come from outside; second stage is read, and the bus lines also through one more delay stage for edges
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sel_s <= 2'h0;
            sd_s <= 2'h0;
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            sel_s <= {sel_s[0], input_select_pin};
            sd_s <= {sd_s[0], shutdown_or_enable_pin};
            scl_s <= {scl_s[0], scl_in};
            sda_s <= {sda_s[0], sda_in};
            scl_d <= scl_s[1];
            sda_d <= sda_s[1];
        end
    end

    assign scl_rise = scl_s[1] & ~scl_d;
    assign scl_fall = ~scl_s[1] & scl_d;
    assign start = scl_s[1] & scl_d & sda_d & ~sda_s[1];
    assign stop = scl_s[1] & scl_d & ~sda_d & sda_s[1];
    assign my_addr = cfg.addr_alt ? I2C_ADDR_ALT[7:1] : I2C_ADDR_DEF[7:1];

    // Configuration registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cfg <= CFG_RESET;
        end else if (otp_done && !otp_save) begin
            cfg <= otp_store;
        end else if (reg_wr && !otp_busy) begin
            // Writes during an OTP operation are dropped
            unique case (reg_addr)
                REG_PIN: begin
                    cfg.pol <= reg_wdata[PIN_POL_BIT];
                    cfg.func <= reg_wdata[PIN_FUNC_BIT];
                end
                REG_XIN: cfg.xin <= reg_wdata[5:0];
                REG_XOUT: cfg.xout <= reg_wdata[5:0];
                REG_SRC: begin
                    cfg.sm <= reg_wdata[SRC_SM_LSB +: 2];
                    cfg.prim <= reg_wdata[SRC_PRIM_BIT];
                end
                REG_OUT_EN: cfg.oe <= reg_wdata[2:0];
                REG_OUT_SW: cfg.os <= reg_wdata[2:0];
                REG_ADDR_SEL: cfg.addr_alt <= reg_wdata[ADDR_ALT_BIT];
                default: cfg <= cfg;
            endcase
        end
    end

    assign req_save = (reg_wr && reg_addr == REG_OTP && reg_wdata[OTP_SAVE_BIT])
                      || (go && cmd == CMD_SAVE);
    assign req_restore = (reg_wr && reg_addr == REG_OTP && reg_wdata[OTP_RESTORE_BIT])
                         || (go && cmd == CMD_RESTORE);
    assign otp_done = otp_busy && otp_cnt == 9'h000;

    // OTP engine; a request arriving while busy is not queued
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            otp_busy <= 1'b0;
            otp_cnt <= 9'h000;
            otp_save <= 1'b0;
            por_pend <= 1'b1;
        end else if (!otp_busy && (por_pend || req_save || req_restore)) begin
            otp_busy <= 1'b1;
            otp_cnt <= 9'(OTP_OP_CYC - 1);
            otp_save <= !por_pend && req_save;
            por_pend <= 1'b0;
        end else if (otp_busy) begin
            if (otp_done) begin
                otp_busy <= 1'b0;
            end else begin
                otp_cnt <= otp_cnt - 9'h001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            otp_store <= OTP_FACTORY;
        end else if (otp_done && otp_save) begin
            otp_store <= cfg;
        end
    end

    // Serial command slave: address byte, one command byte, then STOP
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ist <= I_IDLE;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            cmd <= 8'h00;
            cmd_ok <= 1'b0;
            sda_oe <= 1'b0;
            go <= 1'b0;
        end else begin
            go <= 1'b0;
            if (start) begin
                ist <= I_ADDR;
                bitcnt <= 4'h0;
                cmd_ok <= 1'b0;
                sda_oe <= 1'b0;
            end else if (stop) begin
                ist <= I_IDLE;
                sda_oe <= 1'b0;
                go <= cmd_ok;
                cmd_ok <= 1'b0;
            end else begin
                unique case (ist)
                    I_IDLE, I_SKIP: begin
                        sda_oe <= 1'b0;
                    end
                    I_ADDR, I_DATA: begin
                        if (scl_rise && bitcnt != 4'h8) begin
                            shreg <= {shreg[6:0], sda_s[1]};
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl_fall && bitcnt == 4'h8) begin
                            if (ist == I_ADDR) begin
                                // Busy: address is not acknowledged
                                if (shreg[7:1] == my_addr && !shreg[0] && !otp_busy) begin
                                    sda_oe <= 1'b1;
                                    ist <= I_ACK;
                                end else begin
                                    ist <= I_SKIP;
                                end
                            end else if (!cmd_ok && (shreg == CMD_SAVE
                                                     || shreg == CMD_RESTORE)) begin
                                cmd <= shreg;
                                cmd_ok <= 1'b1;
                                sda_oe <= 1'b1;
                                ist <= I_ACK;
                            end else begin
                                // A third byte cancels the command
                                cmd_ok <= 1'b0;
                                ist <= I_SKIP;
                            end
                        end
                    end
                    I_ACK: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            ist <= I_DATA;
                            bitcnt <= 4'h0;
                        end
                    end
                    default: ist <= I_IDLE;
                endcase
            end
        end
    end

    // Open drain: only ever pulls low
    always_ff @(posedge sys_clk) begin
        sda_out <= 1'b0;
    end

    assign want_src = cfg.prim ^ sel_s[1];
    assign manual = !cfg.sm[1];
    assign gated = sw != W_RUN;

    // Outputs are parked before and after the swap, so no runt pulse escapes
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sw <= W_RUN;
            gcnt <= 5'h00;
            active_src <= 1'b0;
        end else begin
            unique case (sw)
                W_RUN: begin
                    if (manual && want_src != active_src) begin
                        sw <= W_GATE;
                        gcnt <= 5'(SW_GAP_CYC - 1);
                    end
                end
                W_GATE: begin
                    if (gcnt == 5'h00) begin
                        active_src <= ~active_src;
                        sw <= W_SETTLE;
                        gcnt <= 5'(SW_GAP_CYC - 1);
                    end else begin
                        gcnt <= gcnt - 5'h01;
                    end
                end
                W_SETTLE: begin
                    if (gcnt == 5'h00) begin
                        sw <= W_RUN;
                    end else begin
                        gcnt <= gcnt - 5'h01;
                    end
                end
                default: sw <= W_RUN;
            endcase
        end
    end

    // Enable pin: level equal to the polarity bit keeps outputs running
    assign pin_asserted = sd_s[1] ^ cfg.pol;
    assign shutdown = cfg.func & sd_s[1];

    always_comb begin
        next_ctrl.power_down = shutdown;
        next_ctrl.ref_sel = active_src;
        next_ctrl.xin_trim = cfg.xin;
        next_ctrl.xout_trim = cfg.xout;
        next_ctrl.out_mode = 6'h00;
        for (int i = 0; i < OUT_NUM; i++) begin
            if (shutdown || gated) begin
                next_ctrl.out_mode[2*i +: 2] = OM_HILO;
            end else begin
                next_ctrl.out_mode[2*i +: 2] = out_mode_f(cfg, pin_asserted, i);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            clk_ctrl <= '0;
        end else begin
            clk_ctrl <= next_ctrl;
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            REG_PIN: next_rdata = {6'h00, cfg.pol, cfg.func};
            REG_XIN: next_rdata = {2'h0, cfg.xin};
            REG_XOUT: next_rdata = {2'h0, cfg.xout};
            REG_SRC: next_rdata = {cfg.sm, 4'h0, cfg.prim, 1'b0};
            REG_OUT_EN: next_rdata = {5'h00, cfg.oe};
            REG_OUT_SW: next_rdata = {5'h00, cfg.os};
            REG_ADDR_SEL: next_rdata = {7'h00, cfg.addr_alt};
            REG_STATUS: next_rdata = {4'h0, gated, otp_busy, shutdown, active_src};
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data live only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_addr_end;
        ist == I_ADDR && scl_fall && bitcnt == 4'h8;
    endsequence

    sequence s_release;
        $fell(sys_rst);
    endsequence

    sequence s_swap;
        sw == W_GATE && gcnt == 5'h00;
    endsequence

    a_xor_select: assert property (
        (sw == W_RUN && manual && want_src != active_src) |=> sw == W_GATE)
        else $error("source mismatch did not start a switch");

    a_manual_only: assert property (
        (sw == W_RUN && cfg.sm[1]) |=> sw == W_RUN)
        else $error("switch started outside manual mode");

    a_swap_step: assert property (
        s_swap |=> active_src != $past(active_src) ##1 gated)
        else $error("source not swapped while gated");

    a_switch_parked: assert property (
        gated |=> clk_ctrl.out_mode == ALL_HILO)
        else $error("outputs not parked during switch");

    a_src_stable: assert property (
        $changed(active_src) |-> $past(sw) == W_GATE)
        else $error("source changed outside gate window");

    a_otp_save: assert property (
        (otp_done && otp_save) |=> otp_store == $past(cfg))
        else $error("save did not copy registers");

    a_otp_restore: assert property (
        (otp_done && !otp_save) |=> cfg == $past(otp_store))
        else $error("restore did not reload registers");

    a_otp_length: assert property (
        $rose(otp_busy) |-> otp_busy [*8])
        else $error("otp operation ended early");

    a_go_on_stop: assert property (
        go |-> $past(stop) && !$past(otp_busy))
        else $error("command started without stop");

    a_nack_busy: assert property (
        (s_addr_end and otp_busy) |=> !sda_oe && ist == I_SKIP)
        else $error("address acknowledged while busy");

    a_por_restore: assert property (
        s_release |=> otp_busy && !otp_save)
        else $error("no restore after reset");

    a_addr_match: assert property (
        (s_addr_end and (shreg[7:1] != my_addr)) |=> ist == I_SKIP && !sda_oe)
        else $error("foreign address acknowledged");

    a_shutdown_all: assert property (
        (cfg.func && sd_s[1]) |=> clk_ctrl.power_down && clk_ctrl.out_mode == ALL_HILO)
        else $error("global shutdown not applied");

    a_tristate: assert property (
        (!shutdown && !gated && !cfg.os[0]) |=> clk_ctrl.out_mode[1:0] == OM_TRI)
        else $error("switch bit zero not tri-stated");

    a_oe_disable: assert property (
        (!cfg.func && !gated && cfg.os[0] && cfg.oe[0] && sd_s[1] != cfg.pol)
        |=> clk_ctrl.out_mode[1:0] == OM_HILO)
        else $error("asserted enable pin did not disable");

    a_oe_active: assert property (
        (!shutdown && !gated && cfg.os[1] && !cfg.oe[1])
        |=> clk_ctrl.out_mode[3:2] == OM_ACTIVE)
        else $error("enabled output not active");

    a_trim_pass: assert property (
        1'b1 |=> clk_ctrl.xin_trim == $past(cfg.xin)
                 && clk_ctrl.xout_trim == $past(cfg.xout))
        else $error("trim codes not forwarded");

endmodule

`default_nettype wire

// >>> sim/rcsoc_i2c_master.sv
// Serial bus master model for the reference select block
`timescale 1ns/10ps
`default_nettype none

module rcsoc_i2c_master (
    input wire logic sys_clk,
    input wire logic sda_line,
    output logic scl_line,
    output logic sda_low
);
    // Clock stands high between frames; data released to the pull-up
    initial begin
        scl_line = 1'b1;
        sda_low = 1'b0;
    end

    // Quarter of the 80 ns link period
    task automatic qtr();
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_low <= ~b[i];
            qtr();
            scl_line <= 1'b1;
            qtr();
            qtr();
            scl_line <= 1'b0;
            qtr();
        end
        sda_low <= 1'b0;
        qtr();
        scl_line <= 1'b1;
        qtr();
        ack = ~sda_line;
        qtr();
        scl_line <= 1'b0;
        qtr();
    endtask

    // Address byte with write bit, command byte, then STOP
    task automatic send_cmd(input logic [7:0] addr, input logic [7:0] code,
            output logic [1:0] acks);
        sda_low <= 1'b1;
        qtr();
        scl_line <= 1'b0;
        qtr();
        send_byte(addr, acks[1]);
        send_byte(code, acks[0]);
        sda_low <= 1'b1;
        qtr();
        scl_line <= 1'b1;
        qtr();
        sda_low <= 1'b0;
        qtr();
        qtr();
    endtask
endmodule

`default_nettype wire

// >>> sim/rcsoc_core_tb_top.sv
// Testbench for the reference select and output control block
`timescale 1ns/10ps
`default_nettype none

module rcsoc_core_tb_top import rcsoc_pkg::*;;
    logic sys_clk, sys_rst, input_select_pin, shutdown_or_enable_pin;
    logic reg_wr, reg_rd, otp_busy, sda_out, sda_oe, scl_line, sda_low;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    rcsoc_ctrl_t clk_ctrl;
    wire logic sda_line;
    int num_errors, total_checks;

    // Open drain with pull-up: low if either party pulls
    assign sda_line = ~(sda_low | (sda_oe & ~sda_out));

    rcsoc_core i_rcsoc_core (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .input_select_pin(input_select_pin), .shutdown_or_enable_pin(shutdown_or_enable_pin),
        .scl_in(scl_line), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .clk_ctrl(clk_ctrl), .otp_busy(otp_busy));

    rcsoc_i2c_master i_rcsoc_i2c_master (.sys_clk(sys_clk), .sda_line(sda_line),
        .scl_line(scl_line), .sda_low(sda_low));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic wrap_up();
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(name, 20'(exp), 20'(reg_rdata));
    endtask

    task automatic wait_busy(input logic lvl, input int bound);
        int n;
        n = 0;
        while (otp_busy !== lvl && n < bound) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (otp_busy !== lvl) begin
            num_errors++;
            $display("ERROR otp_busy expected %b seen %b", lvl, otp_busy);
            wrap_up();
        end
    endtask

    // Outputs must be held disabled at the very cycle the source swaps
    task automatic wait_src(input logic exp);
        logic prev;
        int n;
        prev = clk_ctrl.ref_sel;
        n = 0;
        while (clk_ctrl.ref_sel !== exp && n < 120) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (clk_ctrl.ref_sel !== prev) chk("out_mode at swap", 20'(ALL_HILO), 20'(clk_ctrl.out_mode));
        end
        chk("ref_sel", 20'(exp), 20'(clk_ctrl.ref_sel));
        if (clk_ctrl.ref_sel !== exp) wrap_up();
    endtask

    function automatic logic [1:0] exp_mode(input logic func, input logic pol,
            input logic os, input logic oe, input logic pin);
        if (func && pin) return OM_HILO;
        if (!os) return OM_TRI;
        if (!oe) return OM_ACTIVE;
        if (!func) return ((pin != pol) ? OM_HILO : OM_ACTIVE);
        return (pol ? OM_HILO : OM_ACTIVE);
    endfunction

    initial begin
        logic [1:0] acks;
        logic [5:0] em;
        logic [2:0] os3;
        num_errors = 0;
        total_checks = 0;
        sys_rst = 1'b1;
        input_select_pin = 1'b0;
        shutdown_or_enable_pin = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk("otp_busy after reset", 20'h1, 20'(otp_busy));
        i_rcsoc_i2c_master.send_cmd(I2C_ADDR_DEF, CMD_SAVE, acks);
        chk("acks during restore", 20'h0, 20'(acks));
        wait_busy(1'b0, 500);
        rdchk("switch reset", REG_OUT_SW, 8'h07);
        for (int i = 0; i < 4; i++) begin
            wr(REG_SRC, {1'b0, i[1], 4'h0, i[1], 1'b0});
            input_select_pin <= i[0];
            wait_src(i[1] ^ i[0]);
        end
        wr(REG_SRC, 8'h82);
        input_select_pin <= 1'b0;
        repeat (60) @(posedge sys_clk);
        #1;
        chk("ref_sel held", 20'h0, 20'(clk_ctrl.ref_sel));
        wr(REG_SRC, 8'h02);
        wait_src(1'b1);
        wr(REG_XIN, 8'h3F);
        wr(REG_XOUT, 8'h0B);
        @(posedge sys_clk);
        #1;
        chk("xin_trim", 20'h3F, 20'(clk_ctrl.xin_trim));
        chk("xout_trim", 20'h0B, 20'(clk_ctrl.xout_trim));
        rdchk("xin readback", REG_XIN, 8'h3F);
        // Outputs stay parked until the last swap has settled
        repeat (24) @(posedge sys_clk);
        for (int k = 0; k < 32; k++) begin
            os3 = {1'b0, 1'b1, k[2]};
            wr(REG_PIN, {6'h00, k[3], k[4]});
            wr(REG_OUT_SW, {5'h00, os3});
            wr(REG_OUT_EN, {5'h00, {3{k[1]}}});
            shutdown_or_enable_pin <= k[0];
            repeat (6) @(posedge sys_clk);
            #1;
            for (int o = 0; o < 3; o++) em[2*o+:2] = exp_mode(k[4], k[3], os3[o], k[1], k[0]);
            chk("out_mode", 20'(em), 20'(clk_ctrl.out_mode));
            chk("power_down", 20'(k[4] & k[0]), 20'(clk_ctrl.power_down));
        end
        rdchk("status", REG_STATUS, 8'h03);
        wr(REG_PIN, 8'h00);
        wr(REG_XIN, 8'h2A);
        i_rcsoc_i2c_master.send_cmd(I2C_ADDR_DEF, CMD_SAVE, acks);
        chk("save acks", 20'h3, 20'(acks));
        wait_busy(1'b1, 20);
        wr(REG_XIN, 8'h11);
        i_rcsoc_i2c_master.send_cmd(I2C_ADDR_DEF, CMD_RESTORE, acks);
        chk("acks while busy", 20'h0, 20'(acks));
        wait_busy(1'b0, 500);
        rdchk("write while busy", REG_XIN, 8'h2A);
        wr(REG_XIN, 8'h05);
        wr(REG_ADDR_SEL, 8'h01);
        i_rcsoc_i2c_master.send_cmd(I2C_ADDR_DEF, CMD_RESTORE, acks);
        chk("default addr nack", 20'h0, 20'(acks));
        i_rcsoc_i2c_master.send_cmd(I2C_ADDR_ALT, 8'h55, acks);
        chk("bad code nack", 20'h2, 20'(acks));
        i_rcsoc_i2c_master.send_cmd(I2C_ADDR_ALT, CMD_RESTORE, acks);
        chk("restore acks", 20'h3, 20'(acks));
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 500);
        rdchk("xin restored", REG_XIN, 8'h2A);
        rdchk("addr restored", REG_ADDR_SEL, 8'h00);
        wr(REG_XIN, 8'h07);
        wr(REG_OTP, 8'h01);
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 500);
        rdchk("xin reg restore", REG_XIN, 8'h2A);
        rdchk("unmapped", 8'h20, 8'h00);
        wrap_up();
    end
endmodule

`default_nettype wire
